// ---- src/lpc_delay.sv ----
module lpc_delay
  import lpc_pkg::*;
#(
  parameter int CYCLES = BG_CHARGE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  output logic busy
);

  // ----------------------------------------------------------------
  // one-shot down counter, restart reloads
  // ----------------------------------------------------------------
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] remaining;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remaining <= '0;
    end else if (start) begin
      remaining <= CW'(CYCLES);
    end else if (remaining != '0) begin
      remaining <= remaining - CW'(1);
    end
  end

  assign busy = (remaining != '0);

endmodule

// ---- src/lpc_pkg.sv ----
package lpc_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] RTC_POWER_MANAGEMENT_ADDR = 16'h1930;
  localparam logic [ADDR_W-1:0] REGULATOR_CONTROL_ADDR = 16'h7004;
  localparam logic [ADDR_W-1:0] POWER_STATUS_ADDR = 16'h1934;

  // ----------------------------------------------------------------
  // rtc_power_management fields and reset values
  // ----------------------------------------------------------------
  localparam int RTC_CLOCK_OUTPUT_ENABLE_POS = 0;
  localparam int REGULATOR_SHUTDOWN_POS = 1;
  localparam int BANDGAP_SHUTDOWN_POS = 2;
  localparam int WAKE_PIN_DIRECTION_POS = 3;
  localparam int WAKE_PIN_OUTPUT_VALUE_POS = 4;
  localparam logic RTC_CLOCK_OUTPUT_ENABLE_RST = 1'h0;
  localparam logic REGULATOR_SHUTDOWN_RST = 1'h0;
  localparam logic BANDGAP_SHUTDOWN_RST = 1'h0;
  localparam logic WAKE_PIN_DIRECTION_RST = 1'h0;
  localparam logic WAKE_PIN_OUTPUT_VALUE_RST = 1'h1;

  // ----------------------------------------------------------------
  // regulator_control fields and reset values
  // ----------------------------------------------------------------
  localparam int USB_REGULATOR_ENABLE_POS = 0;
  localparam int CORE_VOLTAGE_SELECT_POS = 1;
  localparam logic CORE_VOLTAGE_SELECT_RST = 1'h0;
  localparam logic USB_REGULATOR_ENABLE_PRE = 1'h1;

  // ----------------------------------------------------------------
  // power_status fields
  // ----------------------------------------------------------------
  localparam int STATUS_READY_POS = 0;
  localparam int STATUS_DOWN_POS = 1;
  localparam int STATUS_CHARGE_POS = 2;
  localparam int STATUS_CORE_STRAP_POS = 3;
  localparam int STATUS_CLK_STRAP_POS = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 64'd20_000_000;
  localparam longint BG_CHARGE_MS = 64'd100;
  localparam int BG_CHARGE_CYCLES = int'((CLK_HZ * BG_CHARGE_MS) / 1000);
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PWR_ON = 3'h1,
    PWR_DOWN = 3'h2,
    PWR_CHARGE = 3'h4
  } lpc_pwr_e;

  typedef struct packed {
    logic wake_in;
    logic rtc_alarm;
    logic core_regulator_disable_strap;
    logic clock_source_strap;
  } lpc_pins_s;

  typedef struct packed {
    logic analog_regulator;
    logic core_regulator;
    logic usb_regulator;
    logic bandgap;
    logic analog_por;
  } lpc_enables_s;

endpackage

// ---- src/lpc_power_control_regs.sv ----
// Summary of operation
// RULE1: either shutdown bit turns analog, core and usb regulators off.
// RULE2: analog regulator is on unless a shutdown bit is set.
// RULE3: bit 2 shuts regulators, analog reset and bandgap.
// RULE4: bit 1 shuts regulators and analog reset, bandgap stays on.
// RULE5: wake pin high or rtc alarm restores regulators after shutdown.
// RULE6: power cycling claim conflicts; wake events clear shutdown here.
// RULE7: after bandgap shutdown wait 100 ms before regulators are ready.
// RULE8: software avoids shutdown bits when regulators are bypassed.
// RULE9: core regulator off and output floating while disable strap high.
// RULE10: core voltage select bit 1, reset 0, 0=1.3 V 1=1.05 V.
// RULE11: usb enable resets to inverse of sampled clock source strap.
// RULE12: clock source strap low makes usb enable writes of 0 ignored.
// RULE13: strap high lets software switch usb regulator freely.
// RULE14: wake output value bit 4, reset 1, 0 pulls pin low.
// RULE15: wake direction bit 3, reset 0, 0 input, 1 open-drain output.
// RULE16: software keeps wake direction as input to wake from idle.
// RULE17: rtc clock output enable bit 0, reset 0.
// RULE18: reserved upper bits read zero and ignore writes.
module lpc_power_control_regs
  import lpc_pkg::*;
#(
  parameter int BG_CHARGE_WAIT = BG_CHARGE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire lpc_pins_s pins,
  output logic wake_pin_o,
  output logic wake_pin_oe,
  output lpc_enables_s enables,
  output logic core_regulator_output_oe,
  output logic usb_regulator_output_oe,
  output logic core_voltage_select,
  output logic rtc_clock_output_enable,
  output logic regulators_ready
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  lpc_pins_s pins_sync;
  logic [3:0] pins_sync_bits;

  lpc_sync #(
    .W(4)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pins),
    .sync_out(pins_sync_bits)
  );

  assign pins_sync = lpc_pins_s'(pins_sync_bits);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic clk_out_en;
  logic reg_shutdown;
  logic bg_shutdown;
  logic wake_dir;
  logic wake_dout;
  logic core_vsel;
  logic usb_en;
  logic strap_taken;
  logic [1:0] settle_cnt;
  logic alarm_prev;
  lpc_pwr_e pwr_state;
  lpc_pwr_e next_pwr_state;
  logic charge_start;
  logic charge_busy;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a == RTC_POWER_MANAGEMENT_ADDR) ||
               (a == REGULATOR_CONTROL_ADDR) ||
               (a == POWER_STATUS_ADDR);
  endfunction

  // byte-lane merge of a 16-bit register with pstrb
  function automatic logic [REG_W-1:0] merge(
    input logic [REG_W-1:0] old,
    input logic [DATA_W-1:0] wd,
    input logic [3:0] strb
  );
    merge = old;
    if (strb[0]) begin
      merge[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      merge[15:8] = wd[15:8];
    end
  endfunction

  logic access;
  logic wr_pm;
  logic wr_rc;
  logic [REG_W-1:0] pm_view;
  logic [REG_W-1:0] rc_view;
  logic [REG_W-1:0] st_view;
  logic [REG_W-1:0] pm_wr;
  logic [REG_W-1:0] rc_wr;

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign access = psel && penable;
  assign pslverr = access && !addr_hit(paddr);
  assign wr_pm = access && pwrite && (paddr == RTC_POWER_MANAGEMENT_ADDR);
  assign wr_rc = access && pwrite && (paddr == REGULATOR_CONTROL_ADDR);
  assign pm_wr = merge(pm_view, pwdata, pstrb);
  assign rc_wr = merge(rc_view, pwdata, pstrb);

  // ----------------------------------------------------------------
  // register read views
  // ----------------------------------------------------------------
  always_comb begin
    pm_view = '0; // [RULE18]
    pm_view[RTC_CLOCK_OUTPUT_ENABLE_POS] = clk_out_en;
    pm_view[REGULATOR_SHUTDOWN_POS] = reg_shutdown;
    pm_view[BANDGAP_SHUTDOWN_POS] = bg_shutdown;
    pm_view[WAKE_PIN_DIRECTION_POS] = wake_dir;
    pm_view[WAKE_PIN_OUTPUT_VALUE_POS] = wake_dout;
  end

  always_comb begin
    rc_view = '0; // [RULE18]
    rc_view[USB_REGULATOR_ENABLE_POS] = usb_en;
    rc_view[CORE_VOLTAGE_SELECT_POS] = core_vsel;
  end

  always_comb begin
    st_view = '0;
    st_view[STATUS_READY_POS] = regulators_ready;
    st_view[STATUS_DOWN_POS] = (pwr_state == PWR_DOWN);
    st_view[STATUS_CHARGE_POS] = (pwr_state == PWR_CHARGE);
    st_view[STATUS_CORE_STRAP_POS] = pins_sync.core_regulator_disable_strap;
    st_view[STATUS_CLK_STRAP_POS] = pins_sync.clock_source_strap;
  end

  // read data is latched in the setup cycle so it is stable in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        RTC_POWER_MANAGEMENT_ADDR: prdata <= {16'h0000, pm_view};
        REGULATOR_CONTROL_ADDR: prdata <= {16'h0000, rc_view};
        POWER_STATUS_ADDR: prdata <= {16'h0000, st_view};
        default: prdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // wake events
  // ----------------------------------------------------------------
  logic wake_event;
  logic alarm_rise;

  // alarm is taken on its rising edge, wake pin as a level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_prev <= 1'b0;
    end else begin
      alarm_prev <= pins_sync.rtc_alarm;
    end
  end

  assign alarm_rise = pins_sync.rtc_alarm && !alarm_prev;
  // pin only wakes while configured as an input
  assign wake_event = (!wake_dir && pins_sync.wake_in) || alarm_rise; // [RULE5] [RULE16]

  // ----------------------------------------------------------------
  // rtc_power_management bits
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_out_en <= RTC_CLOCK_OUTPUT_ENABLE_RST; // [RULE17]
      wake_dir <= WAKE_PIN_DIRECTION_RST; // [RULE15]
      wake_dout <= WAKE_PIN_OUTPUT_VALUE_RST; // [RULE14]
    end else if (wr_pm) begin
      clk_out_en <= pm_wr[RTC_CLOCK_OUTPUT_ENABLE_POS]; // [RULE17]
      wake_dir <= pm_wr[WAKE_PIN_DIRECTION_POS]; // [RULE15]
      wake_dout <= pm_wr[WAKE_PIN_OUTPUT_VALUE_POS]; // [RULE14]
    end
  end

  // wake clears the shutdown bits; a software set in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_shutdown <= REGULATOR_SHUTDOWN_RST;
      bg_shutdown <= BANDGAP_SHUTDOWN_RST;
    end else begin
      if (wr_pm) begin
        reg_shutdown <= pm_wr[REGULATOR_SHUTDOWN_POS]; // [RULE4]
        bg_shutdown <= pm_wr[BANDGAP_SHUTDOWN_POS]; // [RULE3]
      end
      if (wake_event && pwr_state == PWR_DOWN) begin
        if (!(wr_pm && pm_wr[REGULATOR_SHUTDOWN_POS])) begin
          reg_shutdown <= 1'b0; // [RULE6]
        end
        if (!(wr_pm && pm_wr[BANDGAP_SHUTDOWN_POS])) begin
          bg_shutdown <= 1'b0; // [RULE6]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // power state
  // ----------------------------------------------------------------
  logic bg_was_down;

  always_comb begin
    next_pwr_state = pwr_state;
    charge_start = 1'b0;
    case (pwr_state)
      PWR_ON: begin
        if (reg_shutdown || bg_shutdown) begin
          next_pwr_state = PWR_DOWN; // [RULE1]
        end
      end
      PWR_DOWN: begin
        if (wake_event) begin
          if (bg_was_down) begin
            next_pwr_state = PWR_CHARGE; // [RULE7]
            charge_start = 1'b1;
          end else begin
            next_pwr_state = PWR_ON; // [RULE5]
          end
        end
      end
      PWR_CHARGE: begin
        if (reg_shutdown || bg_shutdown) begin
          next_pwr_state = PWR_DOWN;
        end else if (!charge_busy) begin
          next_pwr_state = PWR_ON;
        end
      end
      default: next_pwr_state = PWR_ON;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_state <= PWR_ON;
    end else begin
      pwr_state <= next_pwr_state;
    end
  end

  // remembers whether the bandgap itself went down in this shutdown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bg_was_down <= 1'b0;
    end else if (pwr_state != PWR_DOWN) begin
      bg_was_down <= 1'b0;
    end else if (bg_shutdown) begin
      bg_was_down <= 1'b1; // [RULE3]
    end
  end

  lpc_delay #(
    .CYCLES(BG_CHARGE_WAIT)
  ) u_charge (
    .pclk(pclk),
    .presetn(presetn),
    .start(charge_start),
    .busy(charge_busy)
  );

  // ----------------------------------------------------------------
  // regulator_control bits
  // ----------------------------------------------------------------
  // strap is caught once the synchroniser has settled after release;
  // until then usb stays on, the safe side for a usb-clocked system
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt <= '0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      if (settle_cnt == STRAP_SETTLE) begin
        strap_taken <= 1'b1;
      end else begin
        settle_cnt <= settle_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_vsel <= CORE_VOLTAGE_SELECT_RST; // [RULE10]
    end else if (wr_rc) begin
      core_vsel <= rc_wr[CORE_VOLTAGE_SELECT_POS]; // [RULE10]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_en <= USB_REGULATOR_ENABLE_PRE;
    end else if (!strap_taken) begin
      if (settle_cnt == STRAP_SETTLE) begin
        usb_en <= !pins_sync.clock_source_strap; // [RULE11]
      end
    end else if (!pins_sync.clock_source_strap) begin
      usb_en <= 1'b1; // [RULE12]
    end else if (wr_rc) begin
      usb_en <= rc_wr[USB_REGULATOR_ENABLE_POS]; // [RULE13]
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic regs_off;

  assign regs_off = (pwr_state == PWR_DOWN); // [RULE1]

  always_comb begin
    enables.analog_regulator = !regs_off; // [RULE2]
    enables.core_regulator = !regs_off &&
      !pins_sync.core_regulator_disable_strap; // [RULE9]
    enables.usb_regulator = !regs_off && usb_en; // [RULE13]
    enables.analog_por = !regs_off; // [RULE4]
    enables.bandgap = !(regs_off && bg_was_down) && !bg_shutdown; // [RULE3]
  end

  // output enable low means the regulator pin floats
  assign core_regulator_output_oe = enables.core_regulator; // [RULE9]
  assign usb_regulator_output_oe = enables.usb_regulator; // [RULE13]
  assign core_voltage_select = core_vsel; // [RULE10]
  assign rtc_clock_output_enable = clk_out_en; // [RULE17]
  assign regulators_ready = (pwr_state == PWR_ON); // [RULE7]

  // open drain: drives low only as an output with value 0
  assign wake_pin_o = 1'b0;
  assign wake_pin_oe = wake_dir && !wake_dout; // [RULE14] [RULE15]

endmodule

// ---- src/lpc_sync.sv ----
module lpc_sync
  import lpc_pkg::*;
#(
  parameter int W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // ----------------------------------------------------------------
  // two-stage synchroniser; first stage feeds only the second
  // ----------------------------------------------------------------
  logic [W-1:0] stage1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// ---- tb/lpc_asserts.sv ----
module lpc_asserts
  import lpc_pkg::*;
#(
  parameter int BG_CHARGE_WAIT = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire lpc_pins_s pins,
  input wire logic wake_pin_oe,
  input wire lpc_enables_s enables,
  input wire logic core_regulator_output_oe,
  input wire logic usb_regulator_output_oe,
  input wire logic core_voltage_select,
  input wire logic rtc_clock_output_enable,
  input wire logic regulators_ready
);
  // --------------------
  // helpers
  // --------------------
  logic acc;
  logic wr_pm;
  logic wr_rc;
  logic wr_sd;
  logic quiet;
  int chg;
  assign acc = psel && penable && pwrite && pstrb[0];
  assign wr_pm = acc && paddr == RTC_POWER_MANAGEMENT_ADDR;
  assign wr_rc = acc && paddr == REGULATOR_CONTROL_ADDR;
  assign wr_sd = wr_pm && pwdata[2:1] != 2'h0;
  assign quiet = !pins.wake_in && !pins.rtc_alarm;
  // the charge wait is far too long for a repetition, so count it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg <= 0;
    end else begin
      chg <= (enables.analog_regulator && !regulators_ready) ? chg + 1 : 0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // --------------------
  // assertions
  // --------------------
  AST_BG_OFF: assert property (
    quiet [*4] ##0 (wr_pm && pwdata[2]) |-> ##2 enables == 5'h00)
    else $error("bandgap shutdown left a supply on");
  AST_LDO_OFF: assert property (
    quiet [*4] ##0 (wr_pm && pwdata[2:1] == 2'h1) |-> ##2 enables == 5'h02)
    else $error("regulator shutdown wrong enables");
  AST_ANA_ON: assert property (
    $fell(enables.analog_regulator) |-> $past(wr_sd, 2))
    else $error("analog regulator dropped without shutdown");
  AST_WAKE: assert property (
    ($rose(pins.wake_in) || $rose(pins.rtc_alarm))
      && !enables.analog_regulator |-> ##[1:6] enables.analog_regulator)
    else $error("wake event did not restore regulators");
  AST_CHARGE: assert property (
    $rose(regulators_ready) && $past(enables.analog_regulator)
      |-> chg >= BG_CHARGE_WAIT - 1 && chg <= BG_CHARGE_WAIT + 1)
    else $error("bandgap charge wait wrong length");
  AST_CORE_STRAP: assert property (
    pins.core_regulator_disable_strap [*4]
      |-> !enables.core_regulator && !core_regulator_output_oe)
    else $error("core regulator on with disable strap");
  AST_USB_KEEP: assert property (
    !pins.clock_source_strap [*4] ##0 regulators_ready
      |-> enables.usb_regulator && usb_regulator_output_oe)
    else $error("usb regulator off with strap low");
  AST_WAKE_OE: assert property (
    wr_pm |=> wake_pin_oe == (($past(pwdata) & 32'h18) == 32'h08))
    else $error("wake pin drive wrong");
  AST_CLKOUT: assert property (
    wr_pm |=> rtc_clock_output_enable == $past(pwdata[0]))
    else $error("clock output enable wrong");
  AST_VSEL: assert property (
    wr_rc |=> core_voltage_select == $past(pwdata[1]))
    else $error("core voltage select wrong");
  cover property (wr_sd);
  cover property ($rose(regulators_ready));
  cover property (wr_rc && !pwdata[0]);
endmodule

// ---- tb/lpc_board.sv ----
module lpc_board
  import lpc_pkg::*;
(
  input wire logic pclk,
  input wire logic go,
  input wire logic use_alarm,
  input wire logic [7:0] dly,
  input wire logic core_strap,
  input wire logic clk_strap,
  input wire logic wake_pin_o,
  input wire logic wake_pin_oe,
  output lpc_pins_s pins
);
  // --------------------
  // delayed wake source
  // --------------------
  logic [7:0] cnt = 8'h00;
  logic [2:0] hold = 3'h0;
  logic act;
  always_ff @(posedge pclk) begin
    cnt <= go ? dly : (cnt != 8'h00 ? cnt - 8'h01 : 8'h00);
    hold <= (cnt == 8'h01) ? 3'h4 : (hold != 3'h0 ? hold - 3'h1 : 3'h0);
  end
  assign act = hold != 3'h0;
  // --------------------
  // pin levels
  // --------------------
  // open drain low wins; otherwise the source or the board pull-down
  assign pins.wake_in = wake_pin_oe ? wake_pin_o : act && !use_alarm;
  assign pins.rtc_alarm = act && use_alarm;
  // straps are only moved while the device sits in reset
  assign pins.core_regulator_disable_strap = core_strap;
  assign pins.clock_source_strap = clk_strap;
endmodule

// ---- tb/test_lpc_power_control_regs.sv ----
module test_lpc_power_control_regs import lpc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int W = 20;
  localparam logic [15:0] PM = RTC_POWER_MANAGEMENT_ADDR;
  localparam logic [15:0] RC = REGULATOR_CONTROL_ADDR;
  localparam logic [15:0] ST = POWER_STATUS_ADDR;
  typedef struct packed {
    logic [15:0] a;
    logic [31:0] d;
    logic [3:0] s;
    logic [31:0] r;
    logic e;
    logic [3:0] o;
  } lpc_row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  lpc_pins_s pins;
  logic wake_o;
  logic wake_oe;
  lpc_enables_s enables;
  logic core_oe;
  logic usb_oe;
  logic vsel;
  logic clkout;
  logic ready;
  logic go = 1'b0;
  logic use_alarm = 1'b0;
  logic [7:0] dly = 8'h01;
  logic core_strap = 1'b0;
  logic clk_strap = 1'b0;
  logic [3:0] outs;
  logic [31:0] rd;
  logic er;
  int errors = 0;
  int check_count = 0;
  int n;
  lpc_row_s rows [9] = '{
    '{PM, 32'hFFFF_FFF9, 4'hF, 32'h0000_0019, 1'b0, 4'h3},
    '{PM, 32'h0000_0008, 4'h1, 32'h0000_0008, 1'b0, 4'h9},
    '{PM, 32'h0000_0010, 4'h1, 32'h0000_0010, 1'b0, 4'h1},
    '{RC, 32'hFFFF_FFFE, 4'hF, 32'h0000_0003, 1'b0, 4'h5},
    '{RC, 32'h0000_0000, 4'h3, 32'h0000_0001, 1'b0, 4'h1},
    '{RC, 32'hFFFF_FFFF, 4'h0, 32'h0000_0001, 1'b0, 4'h1},
    '{16'h2000, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000, 1'b1, 4'h1},
    '{PM, 32'h0000_0000, 4'h3, 32'h0000_0000, 1'b0, 4'h1},
    '{ST, 32'hFFFF_FFFF, 4'hF, 32'h0000_0001, 1'b0, 4'h1}
  };
  assign outs = {wake_oe, vsel, clkout, usb_oe};
  lpc_power_control_regs #(.BG_CHARGE_WAIT(W)) lpc_power_control_regs_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .wake_pin_o(wake_o), .wake_pin_oe(wake_oe), .enables(enables),
    .core_regulator_output_oe(core_oe), .usb_regulator_output_oe(usb_oe),
    .core_voltage_select(vsel), .rtc_clock_output_enable(clkout),
    .regulators_ready(ready));
  lpc_board lpc_board_i (.pclk(pclk), .go(go), .use_alarm(use_alarm),
    .dly(dly), .core_strap(core_strap), .clk_strap(clk_strap),
    .wake_pin_o(wake_o), .wake_pin_oe(wake_oe), .pins(pins));
  initial begin
    forever #25 pclk = ~pclk;
  end
  // --------------------
  // tasks
  // --------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait limit here: only the watchdog ends a stuck transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic till(input logic which);
    n = 0;
    while ((which ? ready : enables.analog_regulator) !== 1'b1 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 200) errors++;
  endtask
  // the wake source keeps its kind until the next request
  task automatic fire(input logic alarm, input logic [7:0] d);
    use_alarm <= alarm;
    dly <= d;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
  endtask
  task automatic do_reset(input logic c, input logic k);
    presetn <= 1'b0;
    core_strap <= c;
    clk_strap <= k;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  task automatic done(input string t);
    $display("test %s finished", t);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // --------------------
  // sequence
  // --------------------
  initial begin
    do_reset(1'b0, 1'b0);
    chk(32'(enables), 32'h1F);
    apb(1'b0, PM, '0, '0);
    chk(rd, 32'h10);
    apb(1'b0, RC, '0, '0);
    chk(rd, 32'h1);
    done("reset");
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d, rows[i].s);
      apb(1'b0, rows[i].a, '0, '0);
      chk(rd, rows[i].r);
      chk(32'(er), 32'(rows[i].e));
      chk(32'(outs), 32'(rows[i].o));
    end
    done("table");
    // shutdown only while the internal regulators feed the chip
    apb(1'b1, PM, 32'h2, 4'h1);
    repeat (2) @(posedge pclk);
    chk(32'(enables), 32'h02);
    apb(1'b0, PM, '0, '0);
    chk(rd, 32'h2);
    fire(1'b0, 8'h01);
    till(1'b1);
    chk(32'(enables), 32'h1F);
    apb(1'b0, PM, '0, '0);
    chk(rd, 32'h0);
    done("regulator shutdown");
    repeat (8) @(posedge pclk);
    apb(1'b1, PM, 32'h4, 4'h1);
    repeat (2) @(posedge pclk);
    chk(32'(enables), 32'h00);
    apb(1'b0, ST, '0, '0);
    chk(rd, 32'h2);
    fire(1'b1, 8'h28);
    till(1'b0);
    till(1'b1);
    chk(32'(n >= W - 1 && n <= W + 1), 32'h1);
    done("bandgap shutdown");
    do_reset(1'b1, 1'b1);
    chk(32'({enables.core_regulator, core_oe}), 32'h0);
    apb(1'b0, RC, '0, '0);
    chk(rd, 32'h0);
    apb(1'b1, RC, 32'h1, 4'h1);
    chk(32'(usb_oe), 32'h1);
    apb(1'b1, RC, 32'h0, 4'h1);
    chk(32'(usb_oe), 32'h0);
    done("strap high");
    summarize();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    summarize();
  end
endmodule
bind lpc_power_control_regs lpc_asserts #(.BG_CHARGE_WAIT(BG_CHARGE_WAIT))
  lpc_asserts_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .pins, .wake_pin_oe, .enables, .core_regulator_output_oe,
  .usb_regulator_output_oe, .core_voltage_select, .rtc_clock_output_enable,
  .regulators_ready);
